// file: scps_defs.vh
`ifndef SCPS_DEFS_VH
`define SCPS_DEFS_VH
// Register indices; byte address is four times the index
`define SCPS_IDX_CMD        8'h1E
`define SCPS_IDX_MODE       8'h1F
`define SCPS_IDX_TVEL       8'h21
`define SCPS_IDX_ACC        8'h22
`define SCPS_IDX_DEC        8'h23
`define SCPS_IDX_RTPOS      8'h24
`define SCPS_IDX_RTSPD      8'h25
`define SCPS_IDX_RTCUR      8'h26
`define SCPS_IDX_PRST       8'h27
`define SCPS_IDX_TPOS       8'h20
`define SCPS_IDX_FBPOS      8'h28
`define SCPS_IDX_TQSRC      8'h29
`define SCPS_IDX_MAXCUR     8'h2A
// Command word bits
`define SCPS_CMD_SERVO_ON   0
`define SCPS_CMD_PROFILE    1
`define SCPS_CMD_DEV_CLR    2
`define SCPS_CMD_ALM_CLR    3
`define SCPS_CMD_HARD_STOP  4
`define SCPS_CMD_SMOOTH     5
`define SCPS_CMD_RSVD       6
`define SCPS_CMD_RAMP_EN    7
`define SCPS_CMD_AIN_ZERO   8
`define SCPS_CMD_MODE2      9
`define SCPS_CMD_ILIM2      10
`define SCPS_CMD_GAIN2      11
`define SCPS_CMD_ABS_CLR    12
`define SCPS_CMD_ORIGIN     13
`define SCPS_CMD_POS_RST    14
`define SCPS_CMD_ABS_MT_CLR 15
// Mode encodings
`define SCPS_MODE_OFF       8'h00
`define SCPS_MODE_POS       8'h01
`define SCPS_MODE_VEL       8'h02
`define SCPS_MODE_CUR       8'h03
`define SCPS_MODE_HOME      8'h04
`define SCPS_MODE_INERTIA   8'h05
`define SCPS_MODE_FRICTION  8'h06
`define SCPS_MODE_SIMPLE    8'h0E
// Reset values and limits
`define SCPS_RST_TVEL       16'h0064
`define SCPS_RST_ACC        16'h03E8
`define SCPS_RST_DEC        16'h03E8
`define SCPS_MAX_TVEL       16'h2710
`define SCPS_MAX_SPD        16'h2710
`define SCPS_TQSRC_LIMIT    8'h03
`define SCPS_CMD_MASK       16'hFFBF
`define SCPS_RESP_OKAY      2'b00
`define SCPS_RESP_SLVERR    2'b10
`endif

// file: scps_param_set.v
// Operation
// - Bits 0-5: servo on, profile, deviation clear, alarm clear, hard and smooth stop
// - Bits 7-11: ramp enable, analog zero, mode two, current limit two, gain two
// - Bits 12-15: sensor alarm clear, origin, position reset, sensor and turns clear
// - Mode selector 8 bits: 0 off, 1 position, 2 velocity, 3 current; reset zero
// - Modes 4 homing, 5 inertia, 6 friction, 14 simplified; nothing else written
// - Profile target position signed 32-bit, full range, reset zero
// - Profile target velocity 16-bit rpm, 0 to 10000, reset 100
// - Acceleration in 10 rpm/s, full 16-bit range, reset 1000
// - Deceleration used on smooth stop in velocity or profile, reset 1000
// - Real-time position command drives position target in position mode
// - Real-time speed command drives speed in velocity mode, within +/-10000; with torque source 3 it is a speed limit instead
// - Real-time current command drives current in current mode, within motor maximum
// - Position reset bit loads feedback position with the reset value
// - Feedback position is the pulse position used by the position loop
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
`include "scps_defs.vh"
module scps_param_set #(
   parameter MAX_CURRENT_DEFAULT = 16'h7FFF
) (
   input  wire        CLK,
   input  wire        NRST,
   input  wire [31:0] S_AXI_AWADDR,
   input  wire        S_AXI_AWVALID,
   output wire        S_AXI_AWREADY,
   input  wire [31:0] S_AXI_WDATA,
   input  wire [3:0]  S_AXI_WSTRB,
   input  wire        S_AXI_WVALID,
   output wire        S_AXI_WREADY,
   output reg  [1:0]  S_AXI_BRESP,
   output reg         S_AXI_BVALID,
   input  wire        S_AXI_BREADY,
   input  wire [31:0] S_AXI_ARADDR,
   input  wire        S_AXI_ARVALID,
   output wire        S_AXI_ARREADY,
   output reg  [31:0] S_AXI_RDATA,
   output reg  [1:0]  S_AXI_RRESP,
   output reg         S_AXI_RVALID,
   input  wire        S_AXI_RREADY,
   input  wire        POS_STEP_VALID,
   input  wire [31:0] POS_STEP,
   output reg  [15:0] CMD_BITS,
   output reg  [7:0]  MODE,
   output reg  [31:0] POS_TARGET,
   output reg  [31:0] PROFILE_TARGET_POS,
   output reg  [15:0] PROFILE_VEL,
   output reg  [15:0] ACCEL,
   output reg  [15:0] ACTIVE_DECEL,
   output reg         DECEL_ACTIVE,
   output reg  [15:0] SPEED_CMD,
   output reg         SPEED_CMD_VALID,
   output reg  [15:0] SPEED_LIMIT,
   output reg         SPEED_LIMIT_VALID,
   output reg  [15:0] CURRENT_CMD,
   output reg         CURRENT_CMD_VALID,
   output reg  [31:0] FEEDBACK_POS
);

   reg  [15:0] cmd_reg;
   reg  [7:0]  mode_reg;
   reg  [31:0] tpos_reg;
   reg  [15:0] tvel_reg;
   reg  [15:0] acc_reg;
   reg  [15:0] dec_reg;
   reg  [31:0] rtpos_reg;
   reg  [15:0] rtspd_reg;
   reg  [15:0] rtcur_reg;
   reg  [31:0] prst_reg;
   reg  [31:0] fbpos_reg;
   reg  [7:0]  tqsrc_reg;
   reg  [15:0] maxcur_reg;
   reg         aw_full_reg;
   reg  [31:0] aw_addr_reg;
   reg         w_full_reg;
   reg  [31:0] w_data_reg;
   reg  [3:0]  w_strb_reg;

   // Merges a write into an old value honouring byte strobes
   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0]  strb;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
         end
      end
   endfunction

   // Clamps a signed 16-bit value to +/- limit
   function [15:0] clamp_s16;
      input [15:0] v;
      input [15:0] lim;
      begin
         if (!v[15] && v > lim) begin
            clamp_s16 = lim;
         end else if (v[15] && (16'h0000 - v) > lim) begin
            clamp_s16 = 16'h0000 - lim;
         end else begin
            clamp_s16 = v;
         end
      end
   endfunction

   function mode_legal;
      input [7:0] m;
      begin
         mode_legal = (m <= `SCPS_MODE_FRICTION) || (m == `SCPS_MODE_SIMPLE);
      end
   endfunction

   // Word-aligned and inside the 256-word register window
   function addr_word_ok;
      input [31:0] a;
      begin
         addr_word_ok = (a[31:10] == 22'h000000) && (a[1:0] == 2'b00);
      end
   endfunction

   // Write channel: address and data taken in either order, one at a time
   wire        wr_fire = aw_full_reg && w_full_reg && !S_AXI_BVALID;
   wire [7:0]  wr_idx  = aw_addr_reg[9:2];
   wire        wr_hit  = addr_word_ok(aw_addr_reg);
   wire [31:0] wr_old;
   reg  [31:0] rd_mux;
   reg         rd_ok;

   assign S_AXI_AWREADY = !aw_full_reg;
   assign S_AXI_WREADY  = !w_full_reg;
   // Only one read in flight: a new address waits until the data are taken
   assign S_AXI_ARREADY = !S_AXI_RVALID;

   function [31:0] read_word;
      input [7:0] idx;
      begin
         case (idx)
            `SCPS_IDX_CMD:    read_word = {16'h0000, cmd_reg};
            `SCPS_IDX_MODE:   read_word = {24'h000000, mode_reg};
            `SCPS_IDX_TPOS:   read_word = tpos_reg;
            `SCPS_IDX_TVEL:   read_word = {16'h0000, tvel_reg};
            `SCPS_IDX_ACC:    read_word = {16'h0000, acc_reg};
            `SCPS_IDX_DEC:    read_word = {16'h0000, dec_reg};
            `SCPS_IDX_RTPOS:  read_word = rtpos_reg;
            `SCPS_IDX_RTSPD:  read_word = {16'h0000, rtspd_reg};
            `SCPS_IDX_RTCUR:  read_word = {16'h0000, rtcur_reg};
            `SCPS_IDX_PRST:   read_word = prst_reg;
            `SCPS_IDX_FBPOS:  read_word = fbpos_reg;
            `SCPS_IDX_TQSRC:  read_word = {24'h000000, tqsrc_reg};
            `SCPS_IDX_MAXCUR: read_word = {16'h0000, maxcur_reg};
            default:          read_word = 32'h00000000;
         endcase
      end
   endfunction

   function idx_mapped;
      input [7:0] idx;
      begin
         case (idx)
            `SCPS_IDX_CMD, `SCPS_IDX_MODE, `SCPS_IDX_TPOS, `SCPS_IDX_TVEL,
            `SCPS_IDX_ACC, `SCPS_IDX_DEC, `SCPS_IDX_RTPOS, `SCPS_IDX_RTSPD,
            `SCPS_IDX_RTCUR, `SCPS_IDX_PRST, `SCPS_IDX_FBPOS, `SCPS_IDX_TQSRC,
            `SCPS_IDX_MAXCUR: idx_mapped = 1'b1;
            default:          idx_mapped = 1'b0;
         endcase
      end
   endfunction

   // Feedback position is read-only: writes to it are refused
   function idx_writable;
      input [7:0] idx;
      begin
         idx_writable = idx_mapped(idx) && (idx != `SCPS_IDX_FBPOS);
      end
   endfunction

   assign wr_old = read_word(wr_idx);
   wire [31:0] wr_val = merge(wr_old, w_data_reg, w_strb_reg);
   wire        wr_ok  = wr_hit && idx_writable(wr_idx);
   wire        wr_en  = wr_fire && wr_ok;

   always @* begin
      rd_ok  = addr_word_ok(S_AXI_ARADDR) && idx_mapped(S_AXI_ARADDR[9:2]);
      rd_mux = rd_ok ? read_word(S_AXI_ARADDR[9:2]) : 32'h00000000;
   end

   always @(posedge CLK) begin
      if (!NRST) begin
         aw_full_reg  <= 1'b0;
         aw_addr_reg  <= 32'h00000000;
         w_full_reg   <= 1'b0;
         w_data_reg   <= 32'h00000000;
         w_strb_reg   <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= `SCPS_RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && !w_full_reg) begin
            w_full_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA;
            w_strb_reg <= S_AXI_WSTRB;
         end
         if (wr_fire) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_ok ? `SCPS_RESP_OKAY : `SCPS_RESP_SLVERR;
         end
         if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
         end
      end
   end

   // Read data are captured as the address is taken, so a write landing in
   // that same cycle is seen only by the next read
   always @(posedge CLK) begin
      if (!NRST) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RRESP  <= `SCPS_RESP_OKAY;
         S_AXI_RDATA  <= 32'h00000000;
      end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA  <= rd_mux;
         S_AXI_RRESP  <= rd_ok ? `SCPS_RESP_OKAY : `SCPS_RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end

   // Parameter registers
   always @(posedge CLK) begin
      if (!NRST) begin
         cmd_reg    <= 16'h0000;
         mode_reg   <= `SCPS_MODE_OFF;
         tpos_reg   <= 32'h00000000;
         tvel_reg   <= `SCPS_RST_TVEL;
         acc_reg    <= `SCPS_RST_ACC;
         dec_reg    <= `SCPS_RST_DEC;
         rtpos_reg  <= 32'h00000000;
         rtspd_reg  <= 16'h0000;
         rtcur_reg  <= 16'h0000;
         prst_reg   <= 32'h00000000;
         tqsrc_reg  <= 8'h00;
         maxcur_reg <= MAX_CURRENT_DEFAULT;
      end else begin
         if (wr_en) begin
            case (wr_idx)
               // Reserved bit is forced to zero so a stray write cannot reach it
               `SCPS_IDX_CMD:    cmd_reg <= wr_val[15:0] & `SCPS_CMD_MASK;
               // Illegal mode codes are dropped, keeping the previous mode
               `SCPS_IDX_MODE:   if (mode_legal(wr_val[7:0])) mode_reg <= wr_val[7:0];
               `SCPS_IDX_TPOS:   tpos_reg <= wr_val;
               // Out-of-range velocity saturates rather than being refused
               `SCPS_IDX_TVEL:   tvel_reg <= (wr_val[15:0] > `SCPS_MAX_TVEL)
                                            ? `SCPS_MAX_TVEL : wr_val[15:0];
               `SCPS_IDX_ACC:    acc_reg <= wr_val[15:0];
               `SCPS_IDX_DEC:    dec_reg <= wr_val[15:0];
               `SCPS_IDX_RTPOS:  rtpos_reg <= wr_val;
               // Real-time commands saturate at their bounds as well
               `SCPS_IDX_RTSPD:  rtspd_reg <= clamp_s16(wr_val[15:0], `SCPS_MAX_SPD);
               `SCPS_IDX_RTCUR:  rtcur_reg <= clamp_s16(wr_val[15:0], maxcur_reg);
               `SCPS_IDX_PRST:   prst_reg <= wr_val;
               `SCPS_IDX_TQSRC:  tqsrc_reg <= wr_val[7:0];
               // Top bit kept clear so the signed clamp bounds stay symmetric
               `SCPS_IDX_MAXCUR: maxcur_reg <= {1'b0, wr_val[14:0]};
               default:          prst_reg <= prst_reg;
            endcase
         end else if (cmd_reg[`SCPS_CMD_POS_RST]) begin
            // Position reset acts once; the bit self-clears after loading
            cmd_reg[`SCPS_CMD_POS_RST] <= 1'b0;
         end
      end
   end

   // Feedback position: reset load wins over motion steps in the same cycle
   always @(posedge CLK) begin
      if (!NRST) begin
         fbpos_reg <= 32'h00000000;
      end else if (cmd_reg[`SCPS_CMD_POS_RST]) begin
         fbpos_reg <= prst_reg;
      // Steps wrap modulo 2^32, like a free-running pulse counter
      end else if (POS_STEP_VALID) begin
         fbpos_reg <= fbpos_reg + POS_STEP;
      end
   end

   // Mode and source decodes shared by several outputs
   wire        vel_mode  = (mode_reg == `SCPS_MODE_VEL);
   wire        speed_lim = (tqsrc_reg == `SCPS_TQSRC_LIMIT);

   // Position target holds its last value outside position control
   always @(posedge CLK) begin
      if (!NRST) begin
         POS_TARGET <= 32'h00000000;
      end else if (mode_reg == `SCPS_MODE_POS) begin
         POS_TARGET <= rtpos_reg;
      end
   end

   // Decoded command outputs
   always @(posedge CLK) begin
      if (!NRST) begin
         CMD_BITS           <= 16'h0000;
         MODE               <= `SCPS_MODE_OFF;
         PROFILE_TARGET_POS <= 32'h00000000;
         PROFILE_VEL        <= `SCPS_RST_TVEL;
         ACCEL              <= `SCPS_RST_ACC;
         ACTIVE_DECEL       <= `SCPS_RST_DEC;
         DECEL_ACTIVE       <= 1'b0;
         SPEED_CMD          <= 16'h0000;
         SPEED_CMD_VALID    <= 1'b0;
         SPEED_LIMIT        <= 16'h0000;
         SPEED_LIMIT_VALID  <= 1'b0;
         CURRENT_CMD        <= 16'h0000;
         CURRENT_CMD_VALID  <= 1'b0;
         FEEDBACK_POS       <= 32'h00000000;
      end else begin
         CMD_BITS           <= cmd_reg;
         MODE               <= mode_reg;
         PROFILE_TARGET_POS <= tpos_reg;
         PROFILE_VEL        <= tvel_reg;
         ACCEL              <= acc_reg;
         ACTIVE_DECEL       <= dec_reg;
         // Smooth stop ramps down only where a ramp exists: velocity or profile
         DECEL_ACTIVE       <= cmd_reg[`SCPS_CMD_SMOOTH] &&
                               (vel_mode || cmd_reg[`SCPS_CMD_PROFILE]);
         SPEED_CMD_VALID    <= vel_mode && !speed_lim;
         SPEED_CMD          <= rtspd_reg;
         SPEED_LIMIT_VALID  <= speed_lim;
         SPEED_LIMIT        <= rtspd_reg;
         CURRENT_CMD_VALID  <= (mode_reg == `SCPS_MODE_CUR);
         // Clamped again here so a lowered maximum takes effect at once
         CURRENT_CMD        <= clamp_s16(rtcur_reg, maxcur_reg);
         FEEDBACK_POS       <= fbpos_reg;
      end
   end

endmodule // scps_param_set

// file: scps_props.sv
`timescale 1ns/1ns
module scps_chk (
   input wire        CLK,
   input wire        NRST,
   input wire        S_AXI_AWVALID,
   input wire        S_AXI_AWREADY,
   input wire        S_AXI_WVALID,
   input wire        S_AXI_WREADY,
   input wire [1:0]  S_AXI_BRESP,
   input wire        S_AXI_BVALID,
   input wire        S_AXI_BREADY,
   input wire        S_AXI_ARVALID,
   input wire        S_AXI_ARREADY,
   input wire        S_AXI_RVALID,
   input wire        S_AXI_RREADY,
   input wire [15:0] CMD_BITS,
   input wire [7:0]  MODE,
   input wire [31:0] POS_TARGET,
   input wire [15:0] PROFILE_VEL,
   input wire        DECEL_ACTIVE,
   input wire        SPEED_CMD_VALID,
   input wire        SPEED_LIMIT_VALID,
   input wire        CURRENT_CMD_VALID
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);
   chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
      S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
   chk_wr_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
      S_AXI_WREADY |-> ##[1:3] S_AXI_BVALID) else $error("write response late");
   chk_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
      S_AXI_RVALID && !S_AXI_ARREADY) else $error("read data late");
   chk_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
      else $error("read data dropped");
   chk_rsvd_bit: assert property (CMD_BITS[6] == 1'b0)
      else $error("reserved command bit set");
   chk_mode_legal: assert property (MODE <= 8'h06 || MODE == 8'h0E)
      else $error("illegal mode");
   chk_vel_max: assert property (PROFILE_VEL <= 16'h2710)
      else $error("target velocity above limit");
   chk_decel_cause: assert property (DECEL_ACTIVE |->
      CMD_BITS[5] && (MODE == 8'h02 || CMD_BITS[1])) else $error("decel without cause");
   chk_pos_follow: assert property (!$stable(POS_TARGET) |-> MODE == 8'h01)
      else $error("position target moved outside position mode");
   chk_speed_mode: assert property (SPEED_CMD_VALID |->
      MODE == 8'h02 && !SPEED_LIMIT_VALID) else $error("speed command misqualified");
   chk_cur_mode: assert property (CURRENT_CMD_VALID == (MODE == 8'h03))
      else $error("current command misqualified");
   cov_decel: cover property (DECEL_ACTIVE);
   cov_limit: cover property (SPEED_LIMIT_VALID);
   cov_rd: cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule // scps_chk
bind scps_param_set scps_chk chk_u (.CLK, .NRST, .S_AXI_AWVALID, .S_AXI_AWREADY,
   .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
   .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .CMD_BITS, .MODE,
   .POS_TARGET, .PROFILE_VEL, .DECEL_ACTIVE, .SPEED_CMD_VALID, .SPEED_LIMIT_VALID,
   .CURRENT_CMD_VALID);

// file: scps_host.sv
`timescale 1ns/1ns
`include "scps_defs.vh"
module scps_host (
   input  wire         clk,
   output logic [31:0] awaddr,
   output logic        awvalid,
   input  wire         awready,
   output logic [31:0] wdata,
   output logic [3:0]  wstrb,
   output logic        wvalid,
   input  wire         wready,
   input  wire  [1:0]  bresp,
   input  wire         bvalid,
   output logic        bready,
   output logic [31:0] araddr,
   output logic        arvalid,
   input  wire         arready,
   input  wire  [31:0] rdata,
   input  wire  [1:0]  rresp,
   input  wire         rvalid,
   output logic        rready
);
   initial begin
      {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
      wstrb = 4'hF;
   end
   // Released lines are inverted so a stale value never looks like a request
   task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      @(posedge clk);
      awaddr  <= {22'h0, idx, 2'h0};
      wstrb   <= s;
      wdata   <= (idx == `SCPS_IDX_CMD) ? (d & {16'h0, `SCPS_CMD_MASK}) : d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) begin
            awvalid <= 1'b0;
            awaddr  <= ~awaddr;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            wdata  <= ~wdata;
         end
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr  <= {22'h0, idx, 2'h0};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) begin
            arvalid <= 1'b0;
            araddr  <= ~araddr;
         end
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule // scps_host

// file: tb_top.sv
`timescale 1ns/1ns
`include "scps_defs.vh"
module tb_top;
   logic        clk, nrst, step_v;
   logic [31:0] step, d;
   logic [1:0]  r;
   wire  [31:0] awaddr, wdata, araddr, rdata, pos_tgt, ptpos, fbpos;
   wire  [15:0] cmd_bits, pvel, accel, adec, spd, slim, cur;
   wire  [7:0]  mode;
   wire  [3:0]  wstrb;
   wire  [1:0]  bresp, rresp;
   wire         awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr, dact, spv, slv, cuv;
   integer      error_cnt = 0, compares = 0, cyc = 0;
   logic [7:0]  ri [10] = '{8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
                            8'h26, 8'h27};
   logic [31:0] rv0 [10] = '{0, 0, 0, 32'h64, 32'h3E8, 32'h3E8, 0, 0, 0, 0};
   logic [7:0]  md [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0E};
   scps_host host_u (.clk(clk), .awaddr(awaddr), .awvalid(awv), .awready(awr),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wv), .wready(wr_rdy), .bresp(bresp),
      .bvalid(bv), .bready(br), .araddr(araddr), .arvalid(arv), .arready(arr),
      .rdata(rdata), .rresp(rresp), .rvalid(rv), .rready(rr));
   scps_param_set dut_u (.CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
      .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(br), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
      .S_AXI_RREADY(rr), .POS_STEP_VALID(step_v), .POS_STEP(step), .CMD_BITS(cmd_bits),
      .MODE(mode), .POS_TARGET(pos_tgt), .PROFILE_TARGET_POS(ptpos), .PROFILE_VEL(pvel),
      .ACCEL(accel), .ACTIVE_DECEL(adec), .DECEL_ACTIVE(dact), .SPEED_CMD(spd),
      .SPEED_CMD_VALID(spv), .SPEED_LIMIT(slim), .SPEED_LIMIT_VALID(slv),
      .CURRENT_CMD(cur), .CURRENT_CMD_VALID(cuv), .FEEDBACK_POS(fbpos));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up;
      if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wr(input logic [7:0] i, input logic [31:0] v);
      host_u.wr(i, v, 4'hF, r);
      chk("bresp", {30'h0, r}, 32'h0);
   endtask
   task automatic rdc(input logic [7:0] i, input logic [31:0] e);
      host_u.rd(i, d, r);
      chk("rdata", d, e);
   endtask
   // Outputs lag the registers by one cycle
   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt = error_cnt + 1;
         wrap_up();
      end
   end
   initial begin
      nrst = 1'b0;
      step_v = 1'b0;
      step = 32'h3;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      for (int k = 0; k < 10; k++) rdc(ri[k], rv0[k]);
      for (int b = 0; b < 16; b++) begin
         if (b != 6 && b != 14) begin
            wr(`SCPS_IDX_CMD, 32'h1 << b);
            settle();
            chk("cmd_bits", {16'h0, cmd_bits}, 32'h1 << b);
         end
      end
      foreach (md[k]) begin
         wr(`SCPS_IDX_MODE, {24'h0, md[k]});
         settle();
         chk("mode", {24'h0, mode}, {24'h0, md[k]});
      end
      wr(`SCPS_IDX_MODE, 32'h7);
      settle();
      chk("mode", {24'h0, mode}, 32'hE);
      wr(`SCPS_IDX_TPOS, 32'h80000000);
      rdc(`SCPS_IDX_TPOS, 32'h80000000);
      wr(`SCPS_IDX_TVEL, 32'h2711);
      rdc(`SCPS_IDX_TVEL, 32'h2710);
      wr(`SCPS_IDX_ACC, 32'hFFFF);
      settle();
      chk("accel", {16'h0, accel}, 32'hFFFF);
      chk("ptpos", ptpos, 32'h80000000);
      chk("pvel", {16'h0, pvel}, 32'h2710);
      host_u.wr(`SCPS_IDX_ACC, 32'h1200, 4'h2, r);
      chk("bresp", {30'h0, r}, 32'h0);
      rdc(`SCPS_IDX_ACC, 32'h12FF);
      wr(`SCPS_IDX_MODE, 32'h2);
      wr(`SCPS_IDX_DEC, 32'h1234);
      wr(`SCPS_IDX_CMD, 32'h20);
      wr(`SCPS_IDX_RTSPD, 32'hD8F0);
      settle();
      chk("decel", {dact, adec}, 32'h11234);
      chk("speed", {spv, slv, spd}, 32'h2D8F0);
      wr(`SCPS_IDX_RTSPD, 32'h2711);
      wr(`SCPS_IDX_TQSRC, 32'h3);
      settle();
      chk("limit", {spv, slv, slim}, 32'h12710);
      wr(`SCPS_IDX_TQSRC, 32'h0);
      wr(`SCPS_IDX_MODE, 32'h1);
      wr(`SCPS_IDX_RTPOS, 32'hFFFF0001);
      settle();
      chk("pos_target", pos_tgt, 32'hFFFF0001);
      wr(`SCPS_IDX_MODE, 32'h3);
      wr(`SCPS_IDX_MAXCUR, 32'h100);
      wr(`SCPS_IDX_RTCUR, 32'hFF38);
      wr(`SCPS_IDX_RTPOS, 32'h00000005);
      settle();
      chk("current", {dact, cuv, cur}, 32'h1FF38);
      chk("pos_hold", pos_tgt, 32'hFFFF0001);
      wr(`SCPS_IDX_RTCUR, 32'h200);
      settle();
      chk("current", {16'h0, cur}, 32'h100);
      wr(`SCPS_IDX_MAXCUR, 32'h80);
      settle();
      chk("current", {16'h0, cur}, 32'h80);
      wr(`SCPS_IDX_PRST, 32'h12345678);
      wr(`SCPS_IDX_CMD, 32'h4000);
      settle();
      chk("fbpos", fbpos, 32'h12345678);
      rdc(`SCPS_IDX_CMD, 32'h0);
      step_v <= 1'b1;
      repeat (4) @(posedge clk);
      step_v <= 1'b0;
      rdc(`SCPS_IDX_FBPOS, 32'h12345684);
      host_u.wr(`SCPS_IDX_FBPOS, 32'h0, 4'hF, r);
      chk("bresp", {30'h0, r}, 32'h2);
      host_u.rd(8'h2C, d, r);
      chk("rd_err", {r, d[29:0]}, 32'h80000000);
      rdc(`SCPS_IDX_FBPOS, 32'h12345684);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rdc(`SCPS_IDX_FBPOS, 32'h0);
      rdc(`SCPS_IDX_TVEL, 32'h64);
      settle();
      chk("pvel", {16'h0, pvel}, 32'h64);
      wrap_up();
   end
endmodule // tb_top
